// ===== adc_input_routing_regs_tb.sv
`timescale 1ns/100ps
module adc_input_routing_regs_tb;
  import air_pkg::*;
  // ==========================================================================
  // Stimulus, design outputs and the table of ordinary register cases.
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic fs_tick = 1'b0;
  logic [7:0] rd_data;
  logic left_diff_mode, left_connect, right_diff_mode, right_connect, right_adc_power;
  logic [3:0] left_level, right_pga_gain;
  int errors = 0;
  int n_compared = 0;
  // Each row is address, written value and the value that must read back.
  logic [7:0] rows [7][3] = '{'{8'h15, 8'hff, 8'hf8}, '{8'h15, 8'h07, 8'h00},
    '{8'h15, 8'h40, 8'h40}, '{8'h15, 8'h38, 8'h38}, '{8'h16, 8'h47, 8'h47},
    '{8'h16, 8'h3a, 8'h3a}, '{8'h16, 8'hfe, 8'hfe}};
  air_routing_regs i_air_routing_regs (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .fs_tick(fs_tick), .rd_data(rd_data),
    .left_diff_mode(left_diff_mode), .left_connect(left_connect), .left_level(left_level),
    .right_diff_mode(right_diff_mode), .right_connect(right_connect),
    .right_pga_gain(right_pga_gain), .right_adc_power(right_adc_power));
  // The clock runs at 10 MHz.
  initial begin
    forever #50 clk = ~clk;
  end
  // ==========================================================================
  // Bus cycles, sample ticks and the one comparison used for every result.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk("rd_data", exp, rd_data);
  endtask
  // Waits two edges so both stored fields and immediate gains have landed.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic tick(input int n, input logic [3:0] g);
    repeat (n) begin
      @(posedge clk);
      fs_tick <= 1'b1;
      @(posedge clk);
      fs_tick <= 1'b0;
    end
    settle();
    chk("right_pga_gain", {4'h0, g}, {4'h0, right_pga_gain});
  endtask
  task automatic end_sim();
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A hang is cut off well beyond the hundred or so cycles the tests need.
  initial begin
    #500000;
    errors++;
    end_sim();
  end
  // ==========================================================================
  // Main sequence: reset values, table rows, then unmapped access and stepping.
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(LEFT_ROUTE_OFS, 8'h78);
    rd(RIGHT_ROUTE_OFS, 8'h78);
    chk("connects", 8'h00, {6'h00, left_connect, right_connect});
    chk("power_gain", 8'h0f, {3'h0, right_adc_power, right_pga_gain});
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2]);
      if (rows[i][0] == LEFT_ROUTE_OFS) begin
        chk("left", {2'h0, rows[i][2][7], rows[i][2][6:3] <= 4'h8, rows[i][2][6:3]},
          {2'h0, left_diff_mode, left_connect, left_level});
      end else begin
        chk("right", {5'h00, rows[i][2][7], rows[i][2][6:3] <= 4'h8, rows[i][2][2]},
          {5'h00, right_diff_mode, right_connect, right_adc_power});
      end
    end
    wr(8'h17, 8'hff);
    rd(8'h17, 8'h00);
    rd(LEFT_ROUTE_OFS, 8'h38);
    wr(RIGHT_ROUTE_OFS, 8'h14);
    tick(0, 4'h2);
    wr(RIGHT_ROUTE_OFS, 8'h2c);
    tick(0, 4'h2);
    tick(1, 4'h3);
    tick(1, 4'h4);
    tick(1, 4'h5);
    wr(RIGHT_ROUTE_OFS, 8'h15);
    tick(2, 4'h4);
    tick(2, 4'h3);
    wr(RIGHT_ROUTE_OFS, 8'h42);
    tick(0, 4'h8);
    wr(RIGHT_ROUTE_OFS, 8'h07);
    tick(0, 4'h0);
    // A second reset in mid-run must bring every field back to its reset value.
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(LEFT_ROUTE_OFS, 8'h78);
    rd(RIGHT_ROUTE_OFS, 8'h78);
    chk("connects", 8'h00, {6'h00, left_connect, right_connect});
    chk("power_gain", 8'h0f, {3'h0, right_adc_power, right_pga_gain});
    end_sim();
  end
endmodule

// ===== air_pkg.sv
package air_pkg;
  // ==========================================================================
  // Bus and register map.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] LEFT_ROUTE_OFS = 8'h15;
  localparam logic [7:0] RIGHT_ROUTE_OFS = 8'h16;
  // ==========================================================================
  // Field positions inside the routing registers; power and rate bits are used only in the right one.
  localparam int MODE_BIT = 7;
  localparam int LEVEL_MSB = 6;
  localparam int LEVEL_LSB = 3;
  localparam int POWER_BIT = 2;
  localparam int RATE_MSB = 1;
  localparam int RATE_LSB = 0;
  // ==========================================================================
  // Level codes, rate codes, the left write mask and values after reset.
  localparam logic [3:0] LEVEL_MAX = 4'h8;
  localparam logic [3:0] LEVEL_OFF = 4'hf;
  localparam logic [1:0] RATE_EVERY_FS = 2'h0;
  localparam logic [1:0] RATE_EVERY_2FS = 2'h1;
  localparam logic [7:0] LEFT_WRITE_MASK = 8'hf8;
  localparam logic [7:0] LEFT_ROUTE_RST = 8'h78;
  localparam logic [7:0] RIGHT_ROUTE_RST = 8'h78;
endpackage

// ===== air_routing_regs.sv
`timescale 1ns/100ps
// What this block does
// RULE1 - Bit 7 of each routing register picks single-ended (0) or differential (1).
// RULE2 - Software programs the same mode bit in both registers when routing both ways.
// RULE3 - Level codes 0 to 8 give 0 to -12 dB and connect to the left mixer.
// RULE4 - The same codes in the right register connect to the right mixer.
// RULE5 - Level code 1111 disconnects; it is the reset value of the field.
// RULE6 - Software never writes the reserved level codes 1001 to 1110.
// RULE7 - Left register bits 2 to 0 read as zero; software writes zeros there.
// RULE8 - Right register bit 2 powers the right channel up; it resets to zero.
// RULE9 - Right bits 1 to 0 set stepping: every sample, every two samples, or off.
// RULE10 - Stepping walks the applied gain one code per interval; off means immediate.
module air_routing_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [air_pkg::ADDR_W-1:0] addr,
  input wire logic [air_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic fs_tick,
  output logic [air_pkg::DATA_W-1:0] rd_data,
  output logic left_diff_mode,
  output logic left_connect,
  output logic [3:0] left_level,
  output logic right_diff_mode,
  output logic right_connect,
  output logic [3:0] right_pga_gain,
  output logic right_adc_power
);
  import air_pkg::*;

  logic [7:0] left_route;
  logic [7:0] right_route;
  logic [7:0] next_left_route;
  logic [7:0] next_right_route;
  logic [7:0] next_rd_data;
  logic next_left_connect;
  logic next_right_connect;
  logic [3:0] next_right_pga_gain;
  logic fs_phase;
  logic next_fs_phase;
  logic step_due;
  logic [3:0] right_target;
  logic [1:0] right_rate;

  assign right_target = right_route[LEVEL_MSB:LEVEL_LSB];
  assign right_rate = right_route[RATE_MSB:RATE_LSB];

  // ==========================================================================
  // Register writes and reads.
  // The left register never stores its low bits, so they cannot read back set.
  always_comb begin
    next_left_route = left_route;
    next_right_route = right_route;
    next_rd_data = 8'h00;
    if (wr_en && addr == LEFT_ROUTE_OFS) begin
      next_left_route = wr_data & LEFT_WRITE_MASK; // [RULE7]
    end
    if (wr_en && addr == RIGHT_ROUTE_OFS) begin
      next_right_route = wr_data; // [RULE8] [RULE9]
    end
    // A code above the last gain step leaves the input disconnected.
    next_left_connect = next_left_route[LEVEL_MSB:LEVEL_LSB] <= LEVEL_MAX; // [RULE3] [RULE5]
    next_right_connect = next_right_route[LEVEL_MSB:LEVEL_LSB] <= LEVEL_MAX; // [RULE4] [RULE5]
    if (rd_en) begin
      if (addr == LEFT_ROUTE_OFS) begin
        next_rd_data = left_route; // [RULE7]
      end else if (addr == RIGHT_ROUTE_OFS) begin
        next_rd_data = right_route;
      end
    end
  end

  // ==========================================================================
  // Soft stepping of the applied right gain.
  // A jump to or from the disconnected code is taken at once, since there
  // is no gain between a code and an open switch to walk through.
  // The half-rate phase is never cleared by a write, so a new slow step may
  // wait one extra sample tick; this costs at most one sample of latency.
  always_comb begin
    next_fs_phase = fs_phase;
    if (fs_tick) begin
      next_fs_phase = !fs_phase;
    end
    step_due = fs_tick && (right_rate == RATE_EVERY_FS ||
                           (right_rate == RATE_EVERY_2FS && fs_phase)); // [RULE9]
    next_right_pga_gain = right_pga_gain;
    if (right_rate[1] || right_target > LEVEL_MAX || right_pga_gain > LEVEL_MAX) begin
      next_right_pga_gain = right_target; // [RULE9] [RULE10]
    end else if (step_due && right_pga_gain < right_target) begin
      next_right_pga_gain = right_pga_gain + 4'h1; // [RULE10]
    end else if (step_due && right_pga_gain > right_target) begin
      next_right_pga_gain = right_pga_gain - 4'h1; // [RULE10]
    end
  end

  // ==========================================================================
  // State and output flops; outputs other than right_pga_gain and rd_data track the registers from the same edge.
  // Connect flags are decoded in the write logic, so this block only registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left_route <= LEFT_ROUTE_RST; // [RULE5]
      right_route <= RIGHT_ROUTE_RST; // [RULE5] [RULE8]
      rd_data <= 8'h00;
      fs_phase <= 1'b0;
      right_pga_gain <= LEVEL_OFF;
      left_diff_mode <= 1'b0;
      left_connect <= 1'b0;
      left_level <= LEVEL_OFF;
      right_diff_mode <= 1'b0;
      right_connect <= 1'b0;
      right_adc_power <= 1'b0;
    end else begin
      left_route <= next_left_route;
      right_route <= next_right_route;
      rd_data <= next_rd_data;
      fs_phase <= next_fs_phase;
      right_pga_gain <= next_right_pga_gain;
      left_diff_mode <= next_left_route[MODE_BIT]; // [RULE1]
      left_level <= next_left_route[LEVEL_MSB:LEVEL_LSB];
      left_connect <= next_left_connect; // [RULE3] [RULE5]
      right_diff_mode <= next_right_route[MODE_BIT]; // [RULE1]
      right_connect <= next_right_connect; // [RULE4] [RULE5]
      right_adc_power <= next_right_route[POWER_BIT]; // [RULE8]
    end
  end

  // ==========================================================================
  // Assertions and covers.
  a_left_mode_write: assert property ( // [RULE1]
    @(posedge clk) disable iff (sys_rst)
    (wr_en && addr == LEFT_ROUTE_OFS) |=> left_diff_mode == $past(wr_data[MODE_BIT]))
    else $error("Left mode bit did not follow the write.");

  a_left_connect_map: assert property ( // [RULE3]
    @(posedge clk) disable iff (sys_rst)
    (wr_en && addr == LEFT_ROUTE_OFS)
      |=> left_connect == ($past(wr_data[LEVEL_MSB:LEVEL_LSB]) <= LEVEL_MAX))
    else $error("Left connect does not match the level code.");

  a_right_connect_map: assert property ( // [RULE4]
    @(posedge clk) disable iff (sys_rst)
    (wr_en && addr == RIGHT_ROUTE_OFS)
      |=> right_connect == ($past(wr_data[LEVEL_MSB:LEVEL_LSB]) <= LEVEL_MAX))
    else $error("Right connect does not match the level code.");

  a_reset_disconnect: assert property ( // [RULE5]
    @(posedge clk)
    sys_rst |=> (!left_connect && !right_connect && left_level == LEVEL_OFF))
    else $error("Inputs not disconnected after reset.");

  a_left_low_zero: assert property ( // [RULE7]
    @(posedge clk) disable iff (sys_rst)
    (rd_en && addr == LEFT_ROUTE_OFS) |=> rd_data[2:0] == 3'h0)
    else $error("Left register low bits read nonzero.");

  a_power_write: assert property ( // [RULE8]
    @(posedge clk) disable iff (sys_rst)
    (wr_en && addr == RIGHT_ROUTE_OFS) |=> right_adc_power == $past(wr_data[POWER_BIT]))
    else $error("Right power bit did not follow the write.");

  a_step_off_now: assert property ( // [RULE9]
    @(posedge clk) disable iff (sys_rst)
    (wr_en && addr == RIGHT_ROUTE_OFS && wr_data[RATE_MSB]) ##1 !wr_en
      |=> right_pga_gain == $past(wr_data[LEVEL_MSB:LEVEL_LSB], 2))
    else $error("Gain not applied at once with stepping off.");

  a_step_holds: assert property ( // [RULE10]
    @(posedge clk) disable iff (sys_rst)
    (!right_rate[1] && !fs_tick && right_pga_gain <= LEVEL_MAX && right_target <= LEVEL_MAX)
      |=> $stable(right_pga_gain))
    else $error("Gain moved without a sample tick while stepping.");

  // ==========================================================================
  // Field mirrors, applied-gain steps, reset and read-back checks.
  // Each check pins outputs to what was written, stepped or reset, so a broken
  // decode shows at the very edge that should have moved it.
  a_right_mode_write: assert property ( // [RULE1]
    @(posedge clk) disable iff (sys_rst)
    (wr_en && addr == RIGHT_ROUTE_OFS) |=> right_diff_mode == $past(wr_data[MODE_BIT]))
    else $error("Right mode bit did not follow the write.");

  a_left_level_store: assert property ( // [RULE3]
    @(posedge clk) disable iff (sys_rst)
    (wr_en && addr == LEFT_ROUTE_OFS)
      |=> left_level == $past(wr_data[LEVEL_MSB:LEVEL_LSB]))
    else $error("Left level code did not follow the write.");

  a_reset_power_off: assert property ( // [RULE8]
    @(posedge clk)
    sys_rst |=> (!right_adc_power && right_pga_gain == LEVEL_OFF))
    else $error("Right channel not powered down after reset.");

  a_power_read_back: assert property ( // [RULE8]
    @(posedge clk) disable iff (sys_rst)
    (rd_en && addr == RIGHT_ROUTE_OFS) |=> rd_data[POWER_BIT] == $past(right_adc_power))
    else $error("Power bit read back differs from the power output.");

  a_fast_step: assert property ( // [RULE9] [RULE10]
    @(posedge clk) disable iff (sys_rst)
    (fs_tick && right_rate == RATE_EVERY_FS && right_pga_gain <= LEVEL_MAX &&
     right_target <= LEVEL_MAX && right_pga_gain != right_target)
      |=> right_pga_gain == ($past(right_pga_gain < right_target) ?
                             $past(right_pga_gain) + 4'h1 : $past(right_pga_gain) - 4'h1))
    else $error("Gain did not take one step toward the target on a tick.");

  a_slow_skip: assert property ( // [RULE9]
    @(posedge clk) disable iff (sys_rst)
    (fs_tick && right_rate == RATE_EVERY_2FS && !fs_phase &&
     right_pga_gain <= LEVEL_MAX && right_target <= LEVEL_MAX)
      |=> $stable(right_pga_gain))
    else $error("Gain stepped on the skipped tick at half rate.");

  // Covers mark the main scenarios: a connect, a step at any rate and one at half
  // rate, a power-up and a change of input mode.
  c_left_connect: cover property (@(posedge clk) disable iff (sys_rst) $rose(left_connect));
  c_right_step: cover property (@(posedge clk) disable iff (sys_rst)
    !right_rate[1] && step_due && right_pga_gain != right_target);
  c_power_up: cover property (@(posedge clk) disable iff (sys_rst) $rose(right_adc_power));
  c_slow_step: cover property (@(posedge clk) disable iff (sys_rst)
    right_rate == RATE_EVERY_2FS && step_due && right_pga_gain != right_target);
  c_diff_mode: cover property (@(posedge clk) disable iff (sys_rst) $rose(right_diff_mode));
endmodule
